// ### xps_pkg.sv
// Purpose: Shared constants for the crystal and PLL startup controller.
// Assumes: 250 MHz system clock, 13.56 MHz carrier, 32-bit APB registers.
// Notes: Register indices are word indices; byte address is four times.
package xps_pkg;

	// Register word indices; byte addresses are four times these.
	localparam logic [7:0] IDX_STARTUP_CFG = 8'h0f;
	localparam logic [7:0] IDX_READY_TIMEOUT = 8'h10;
	localparam logic [7:0] IDX_REF_SELECT = 8'h11;
	localparam logic [7:0] IDX_LOCK_TIMING = 8'h12;
	localparam logic [7:0] IDX_CONTROL = 8'h13;
	localparam logic [7:0] IDX_STATUS = 8'h14;
	localparam logic [7:0] IDX_IRQ_STATUS = 8'h15;
	localparam logic [7:0] IDX_IRQ_MASK = 8'h16;

	// Reset values of the configuration registers.
	localparam logic [7:0] RST_STARTUP_CFG = 8'h01;
	localparam logic [7:0] RST_READY_TIMEOUT = 8'h10;
	localparam logic [7:0] RST_REF_SELECT = 8'h08;
	localparam logic [7:0] RST_LOCK_TIMING = 8'h64;
	localparam logic [2:0] RST_IRQ_MASK = 3'h0;

	// Field positions.
	localparam int RECAL_BIT = 0;
	localparam int REF_MSB = 3;
	localparam int RETRY_MSB = 7;
	localparam int RETRY_LSB = 5;
	localparam int INTERVAL_MSB = 4;
	localparam int START_BIT = 0;
	localparam int EV_CLOCK_ERROR = 0;
	localparam int EV_CRYSTAL_READY_TIMEOUT = 1;
	localparam int EV_PLL_LOCKED = 2;

	// PLL reference codes.
	localparam logic [3:0] REF_MAX_EXT = 4'h5;
	localparam logic [3:0] REF_INT_OSC = 4'h7;
	localparam logic [3:0] REF_XTAL = 4'h8;

	// Timing: clock rate, crystal timeout step and carrier divider.
	localparam int CLK_PERIOD_NS = 4;
	localparam int CLK_KHZ = 250000;
	localparam int CARRIER_KHZ = 13560;
	localparam int CARRIER_DIV = CLK_KHZ / CARRIER_KHZ;
	localparam int XTAL_STEP_NS = 128000;
	localparam int XTAL_STEP_CYC =
		(XTAL_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LOCK_UNIT_CARRIER = 256;

	// Startup sequence states.
	typedef enum logic [2:0] {
		XPS_IDLE,
		XPS_RECAL,
		XPS_WAIT_XTAL,
		XPS_LOCK,
		XPS_RETRY_WAIT,
		XPS_READY
	} xps_state_t;

endpackage

// ### xps_clock_startup.sv
// Purpose: Crystal recalibration, readiness timeout and PLL lock retries.
// Assumes: APB slave, one clock, analogue macro inputs are synchronous.
// Notes: Clock error is sticky until software writes a one to clear it.
`timescale 1ns/10ps

// Operation
// - Bit zero enables recalibration at wake-up
// - Crystal wait times out in 128us steps
// - Four-bit code selects PLL reference clock
// - Retry limit exhausted raises clock error
// - Check interval counts 256 carrier cycle units
// - Attempt lock per interval, sample at end
// - Unlocked: retry after another equal interval
module xps_clock_startup #(
	parameter int STEP_CYC = xps_pkg::XTAL_STEP_CYC,
	parameter int CAR_DIV = xps_pkg::CARRIER_DIV
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic reset_n,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Wake-up request and analogue macro status.
	input wire logic wake_up,
	input wire logic xtal_ready,
	input wire logic pll_locked,
	// Analogue macro controls.
	output logic xtal_recal_start,
	output logic pll_enable,
	output logic [3:0] pll_reference_select,
	output logic pll_ready,
	// Interrupt.
	output logic irq
);
	import xps_pkg::*;

	xps_state_t state_q, state_d;
	logic [7:0] cfg_q, tmo_q, ref_q, chk_q;
	logic [2:0] ists_q, imask_q;
	logic [31:0] prdata_q;
	logic pready_q, pslverr_q, recal_q, pll_en_q, pll_rdy_q, irq_q;
	logic [15:0] step_cnt_q;
	logic [4:0] car_div_q;
	logic [7:0] car_cnt_q;
	logic [7:0] units_q;
	logic [2:0] retries_q;

	// Bus decode; the word index is the byte address divided by four.
	wire logic [7:0] widx = paddr[9:2];
	wire logic access = psel && penable && !pready_q;
	wire logic wr_take = psel && penable && pready_q && pwrite;
	wire logic hit_cfg = (widx == IDX_STARTUP_CFG);
	wire logic hit_tmo = (widx == IDX_READY_TIMEOUT);
	wire logic hit_ref = (widx == IDX_REF_SELECT);
	wire logic hit_chk = (widx == IDX_LOCK_TIMING);
	wire logic hit_ctl = (widx == IDX_CONTROL);
	wire logic hit_sts = (widx == IDX_STATUS);
	wire logic hit_ist = (widx == IDX_IRQ_STATUS);
	wire logic hit_imk = (widx == IDX_IRQ_MASK);
	// Refused addresses must not start, clear or write anything.
	wire logic mapped = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0) &&
		(hit_cfg || hit_tmo || hit_ref || hit_chk || hit_ctl ||
		hit_sts || hit_ist || hit_imk);

	// Reference code validity; reserved codes block the ready report.
	wire logic ref_valid = (ref_q[REF_MSB:0] <= REF_MAX_EXT) ||
		(ref_q[REF_MSB:0] == REF_INT_OSC) ||
		(ref_q[REF_MSB:0] == REF_XTAL);

	// Configuration fields.
	wire logic recal_en = cfg_q[RECAL_BIT];
	wire logic [2:0] retry_limit = chk_q[RETRY_MSB:RETRY_LSB];
	wire logic [4:0] interval = chk_q[INTERVAL_MSB:0];
	wire logic [7:0] interval_units = (interval == 5'h00) ? 8'h01 :
		{3'h0, interval};

	// Start request from the wake-up pin or a software write.
	wire logic sw_start = wr_take && mapped && hit_ctl && pwdata[START_BIT];
	wire logic start = wake_up || sw_start;

	// Time bases: crystal timeout step and carrier-derived lock units.
	wire logic step_tick = (step_cnt_q == 16'(STEP_CYC - 1));
	wire logic car_tick = (car_div_q == 5'(CAR_DIV - 1));
	wire logic unit_tick = car_tick &&
		(car_cnt_q == 8'(LOCK_UNIT_CARRIER - 1));
	wire logic interval_end = unit_tick &&
		(units_q == interval_units - 8'h01);
	// Ends after exactly tmo_q whole steps; a zero timeout is handled apart.
	wire logic steps_end = step_tick &&
		(units_q == tmo_q - 8'h01);
	wire logic retries_out = (retries_q == retry_limit);

	// Sequence events.
	wire logic ev_lock = (state_q == XPS_LOCK) && interval_end &&
		pll_locked;
	wire logic ev_fail = (state_q == XPS_LOCK) && interval_end &&
		!pll_locked && retries_out;
	wire logic ev_tmo = (state_q == XPS_WAIT_XTAL) && !xtal_ready &&
		(tmo_q == 8'h00 || steps_end);
	// Event vector in the interrupt status layout.
	wire logic [2:0] events;
	assign events[EV_CLOCK_ERROR] = ev_tmo || ev_fail;
	assign events[EV_CRYSTAL_READY_TIMEOUT] = ev_tmo;
	assign events[EV_PLL_LOCKED] = ev_lock;
	wire logic state_chg = (state_d != state_q);

	// Next-state logic of the startup sequence.
	always_comb begin
		state_d = state_q;
		case (state_q)
			XPS_IDLE, XPS_READY: begin
				if (start) begin
					state_d = recal_en ? XPS_RECAL : XPS_WAIT_XTAL;
				end
			end
			XPS_RECAL: begin
				state_d = XPS_WAIT_XTAL;
			end
			XPS_WAIT_XTAL: begin
				// The timeout only ends a failed wait, never a good one.
				if (xtal_ready) begin
					state_d = XPS_LOCK;
				end else if (ev_tmo) begin
					state_d = XPS_IDLE;
				end
			end
			XPS_LOCK: begin
				if (interval_end) begin
					if (pll_locked) begin
						state_d = XPS_READY;
					end else if (retries_out) begin
						state_d = XPS_IDLE;
					end else begin
						state_d = XPS_RETRY_WAIT;
					end
				end
			end
			XPS_RETRY_WAIT: begin
				if (interval_end) begin
					state_d = XPS_LOCK;
				end
			end
			default: begin
				state_d = XPS_IDLE;
			end
		endcase
	end

	// Read data selection.
	wire logic [31:0] status_word = {17'h0, retries_q, 4'h0,
		pll_rdy_q, ref_valid, xtal_ready, 1'b0, 1'b0, state_q};
	wire logic [31:0] rd_mux =
		hit_cfg ? {24'h0, 7'h0, cfg_q[RECAL_BIT]} :
		hit_tmo ? {24'h0, tmo_q} :
		hit_ref ? {28'h0, ref_q[REF_MSB:0]} :
		hit_chk ? {24'h0, chk_q} :
		hit_sts ? status_word :
		hit_ist ? {29'h0, ists_q} :
		hit_imk ? {29'h0, imask_q} : 32'h0;

	// Sticky status: a set in the same cycle as its clear wins.
	// A write to a refused address clears nothing.
	wire logic [2:0] ist_clr = (wr_take && mapped && hit_ist) ?
		pwdata[2:0] : 3'h0;
	wire logic [2:0] ists_d = (ists_q & ~ist_clr) | events;

	// State register.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= XPS_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// APB answer: one wait state, then data and error with pready.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0;
		end else begin
			pready_q <= access;
			pslverr_q <= access && !mapped;
			prdata_q <= (access && !pwrite && mapped) ? rd_mux : 32'h0;
		end
	end

	// Configuration registers, written at the completing access edge.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cfg_q <= RST_STARTUP_CFG;
			tmo_q <= RST_READY_TIMEOUT;
			ref_q <= RST_REF_SELECT;
			chk_q <= RST_LOCK_TIMING;
			imask_q <= RST_IRQ_MASK;
		end else if (wr_take && mapped) begin
			if (hit_cfg) begin
				cfg_q <= {7'h0, pwdata[RECAL_BIT]};
			end
			if (hit_tmo) begin
				tmo_q <= pwdata[7:0];
			end
			if (hit_ref) begin
				ref_q <= {4'h0, pwdata[REF_MSB:0]};
			end
			if (hit_chk) begin
				chk_q <= pwdata[7:0];
			end
			if (hit_imk) begin
				imask_q <= pwdata[2:0];
			end
		end
	end

	// Interrupt status and the level interrupt.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ists_q <= 3'h0;
			irq_q <= 1'b0;
		end else begin
			ists_q <= ists_d;
			irq_q <= |(ists_d & imask_q);
		end
	end

	// Time bases restart on every state change so each period is whole.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			step_cnt_q <= 16'h0;
			car_div_q <= 5'h0;
			car_cnt_q <= 8'h0;
		end else if (state_chg) begin
			step_cnt_q <= 16'h0;
			car_div_q <= 5'h0;
			car_cnt_q <= 8'h0;
		end else begin
			step_cnt_q <= step_tick ? 16'h0 : step_cnt_q + 16'h1;
			car_div_q <= car_tick ? 5'h0 : car_div_q + 5'h1;
			if (car_tick) begin
				car_cnt_q <= car_cnt_q + 8'h1;
			end
		end
	end

	// Counts timeout steps or interval units within the current state.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			units_q <= 8'h0;
		end else if (state_chg) begin
			units_q <= 8'h0;
		end else if ((state_q == XPS_WAIT_XTAL && step_tick) ||
			(state_q != XPS_WAIT_XTAL && unit_tick)) begin
			units_q <= units_q + 8'h1;
		end
	end

	// Failed lock attempts that were followed by a retry; cleared at each new start.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			retries_q <= 3'h0;
		end else if (state_q == XPS_IDLE || state_q == XPS_READY) begin
			if (start) begin
				retries_q <= 3'h0;
			end
		end else if (state_q == XPS_LOCK && interval_end && !pll_locked &&
			!retries_out) begin
			retries_q <= retries_q + 3'h1;
		end
	end

	// Macro controls; the PLL runs during a lock attempt and stays on while ready.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			recal_q <= 1'b0;
			pll_en_q <= 1'b0;
			pll_rdy_q <= 1'b0;
		end else begin
			recal_q <= (state_d == XPS_RECAL) && state_chg;
			pll_en_q <= (state_d == XPS_LOCK) ||
				(state_d == XPS_READY);
			pll_rdy_q <= (state_d == XPS_READY) && ref_valid;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign xtal_recal_start = recal_q;
	assign pll_enable = pll_en_q;
	assign pll_reference_select = ref_q[REF_MSB:0];
	assign pll_ready = pll_rdy_q;
	assign irq = irq_q;

endmodule

// ### xps_properties.sv
// Purpose: Port-level checks for the crystal and PLL startup block.
// Assumes: One clock domain; reset_n is asynchronous and active low.
// Notes: Sees only the top ports and is attached by bind.
`timescale 1ns/10ps
module xps_properties (
	// Clock and reset.
	input wire logic clk,
	input wire logic reset_n,
	// Register bus.
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Macro side.
	input wire logic pll_locked,
	input wire logic xtal_recal_start,
	input wire logic pll_enable,
	input wire logic [3:0] pll_reference_select,
	input wire logic pll_ready
);
	// All checks share the block clock and its reset.
	default clocking @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	a_answer_wait: assert property (psel && penable && !pready |=> pready)
		else $error("pready missing after one wait state");
	a_pready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
		else $error("prdata not zero outside an answer");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_recal_single: assert property (xtal_recal_start |=>
		!xtal_recal_start && !pll_enable) else $error("recal pulse wrong");
	a_ready_ref_ok: assert property (pll_ready |->
		$past(pll_reference_select) inside {[4'h0:4'h5], 4'h7, 4'h8})
		else $error("ready with reserved reference");
	a_ready_enabled: assert property (pll_ready |-> pll_enable)
		else $error("ready while pll is off");
	a_lock_sampled: assert property ($rose(pll_ready) |->
		$past(pll_locked)) else $error("ready without lock");
	a_enable_drop: assert property ($fell(pll_enable) |-> !pll_ready)
		else $error("ready kept after pll off");
endmodule

// ### xps_analog_model.sv
// Purpose: Behavioural crystal and PLL macros for the startup bench.
// Assumes: One clock; the bench sets failures and a dead crystal.
// Notes: Ready and lock fall to 0, their idle level, when not valid.
`timescale 1ns/10ps
module xps_analog_model (
	// Clock and reset.
	input wire logic clk,
	input wire logic reset_n,
	// Controls and bench settings.
	input wire logic xtal_recal_start,
	input wire logic pll_enable,
	input wire logic xtal_never,
	input wire logic [2:0] fail_n,
	// Status back to the controller.
	output logic xtal_ready,
	output logic pll_locked
);
	logic [3:0] xcnt_q;
	logic [2:0] att_q;
	logic en_q;
	// Crystal settles ten cycles after reset or a recalibration.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			xcnt_q <= 4'h0;
		end else if (xtal_recal_start) begin
			xcnt_q <= 4'h0;
		end else if (xcnt_q != 4'ha) begin
			xcnt_q <= xcnt_q + 4'h1;
		end
	end
	// Attempts are counted on each rise of the PLL enable.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			att_q <= 3'h0;
			en_q <= 1'b1;
		end else begin
			en_q <= pll_enable;
			if (pll_enable && !en_q) begin
				att_q <= att_q + 3'h1;
			end
		end
	end
	assign xtal_ready = !xtal_never && xcnt_q == 4'ha;
	// Lock needs a stable crystal and, for fail_n below 7, comes after fail_n failed tries.
	assign pll_locked = pll_enable && xtal_ready && att_q > fail_n;
endmodule

// ### xps_tb.sv
// Purpose: Self-checking bench for the crystal and PLL startup block.
// Assumes: Short parameters, STEP_CYC 8 and CAR_DIV 2.
// Notes: A monitor compares each bus answer with a queued expectation.
`timescale 1ns/10ps
module testbench;
	import xps_pkg::*;
	logic clk, reset_n, psel, penable, pwrite, pready, pslverr, wake_up;
	logic xtal_ready, pll_locked, xtal_recal_start, pll_enable, pll_ready;
	logic irq, mrst_n, xnever, en_d;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rnd;
	logic [3:0] pll_reference_select;
	logic [2:0] fail_n;
	logic [33:0] exp_q[$], me;
	logic [7:0] ri[6] = '{8'h0f, 8'h10, 8'h11, 8'h12, 8'h13, 8'h16};
	logic [7:0] rv[6] = '{8'h01, 8'h10, 8'h08, 8'h64, 8'h00, 8'h00};
	int error_cnt, num_checks, recal_n, att_n, en_cnt, en_len, wn;
	xps_clock_startup #(.STEP_CYC(8), .CAR_DIV(2)) dut_u (.clk, .reset_n,
		.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .wake_up, .xtal_ready, .pll_locked, .xtal_recal_start,
		.pll_enable, .pll_reference_select, .pll_ready, .irq);
	xps_analog_model mdl_u (.clk, .reset_n(mrst_n), .xtal_recal_start,
		.pll_enable, .xtal_never(xnever), .fail_n, .xtal_ready, .pll_locked);
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	function automatic logic [11:0] ad(input logic [7:0] i);
		return {2'b00, i, 2'b00};
	endfunction
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic conclude();
		$display("checks=%0d errors=%0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// One bus transfer; e is {compare data, error, data}.
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, input logic [33:0] e);
		@(posedge clk);
		exp_q.push_back(e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] i, input logic [31:0] d);
		apb(1'b1, ad(i), d, 34'h0);
	endtask
	task automatic rd(input logic [7:0] i, input logic [31:0] e);
		apb(1'b0, ad(i), 32'h0, {2'b10, e});
	endtask
	task automatic irq_is(input logic v);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, {31'h0, v});
	endtask
	// Fresh macro model, start by pin or register, wait for an outcome.
	task automatic go(input logic [2:0] f, input logic x, input logic pin);
		mrst_n <= 1'b0;
		fail_n <= f;
		xnever <= x;
		att_n = 0;
		recal_n = 0;
		@(posedge clk);
		mrst_n <= 1'b1;
		if (pin) begin
			wake_up <= 1'b1;
			@(posedge clk);
			wake_up <= 1'b0;
		end else wr(IDX_CONTROL, 32'h1);
		repeat (4) @(posedge clk);
		for (wn = 4; wn < 5000; wn++) begin
			@(posedge clk);
			if (irq === 1'b1 || pll_ready === 1'b1) break;
		end
		if (wn == 5000) error_cnt++;
	endtask
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// Counts macro activity and checks each bus answer in order.
	always @(posedge clk) begin
		if (xtal_recal_start === 1'b1) recal_n++;
		if (pll_enable === 1'b1 && !en_d) att_n++;
		if (pll_enable === 1'b1 && !en_d) en_cnt = 0;
		if (pll_enable === 1'b1) en_cnt++;
		else if (en_d) en_len = en_cnt;
		en_d = pll_enable;
		if (pready === 1'b1) begin
			me = exp_q.pop_front();
			chk({31'h0, pslverr}, {31'h0, me[32]});
			if (me[33]) chk(prdata, me[31:0]);
		end
	end
	initial begin
		#100000;
		error_cnt++;
		conclude();
	end
	initial begin
		{psel, penable, pwrite, wake_up, xnever, en_d, mrst_n} = '0;
		{paddr, pwdata, fail_n} = '0;
		reset_n = 1'b0;
		rnd = 32'hed562772;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		mrst_n <= 1'b1;
		foreach (ri[k]) rd(ri[k], {24'h0, rv[k]});
		apb(1'b0, ad(8'h20), 32'h0, {2'b11, 32'h0});
		apb(1'b1, 12'h03d, 32'h0, {2'b01, 32'h0});
		apb(1'b1, 12'h04d, 32'h1, {2'b01, 32'h0});
		rd(IDX_STATUS, 32'h60);
		repeat (4) begin
			rnd = xs(rnd);
			wr(IDX_READY_TIMEOUT, {24'h0, rnd[7:0]});
			rd(IDX_READY_TIMEOUT, {24'h0, rnd[7:0]});
		end
		for (int c = 0; c < 16; c++) begin
			wr(IDX_REF_SELECT, 32'(c));
			rd(IDX_REF_SELECT, 32'(c));
			chk({28'h0, pll_reference_select}, 32'(c));
		end
		// Lock on the second attempt, interrupt masked at first.
		wr(IDX_READY_TIMEOUT, 32'h10);
		wr(IDX_REF_SELECT, 32'h8);
		wr(IDX_LOCK_TIMING, 32'h41);
		go(3'd1, 1'b0, 1'b1);
		chk({31'h0, pll_ready}, 32'h1);
		chk(32'(recal_n), 32'h1);
		chk({31'h0, irq}, 32'h0);
		rd(IDX_STATUS, 32'h10e5);
		rd(IDX_IRQ_STATUS, 32'h4);
		wr(IDX_IRQ_MASK, 32'h7);
		irq_is(1'b1);
		wr(IDX_IRQ_STATUS, 32'h4);
		irq_is(1'b0);
		// No lock at all: two attempts, then a sticky clock error.
		wr(IDX_LOCK_TIMING, 32'h22);
		go(3'd7, 1'b0, 1'b0);
		chk(32'(att_n), 32'h2);
		chk(32'(en_len > 1020 && en_len < 1028), 32'h1);
		repeat (50) @(posedge clk);
		rd(IDX_IRQ_STATUS, 32'h1);
		wr(IDX_IRQ_STATUS, 32'h1);
		rd(IDX_IRQ_STATUS, 32'h0);
		// Dead crystal, no recalibration: timeout after two steps.
		wr(IDX_STARTUP_CFG, 32'h0);
		wr(IDX_READY_TIMEOUT, 32'h2);
		go(3'd0, 1'b1, 1'b1);
		chk(32'(recal_n), 32'h0);
		chk(32'(wn > 14 && wn < 18), 32'h1);
		rd(IDX_IRQ_STATUS, 32'h3);
		wr(IDX_IRQ_STATUS, 32'h3);
		// Reserved reference: locks but never reports ready.
		wr(IDX_REF_SELECT, 32'h6);
		go(3'd0, 1'b0, 1'b1);
		chk({31'h0, pll_ready}, 32'h0);
		rd(IDX_STATUS, 32'h25);
		conclude();
	end
endmodule
bind xps_clock_startup xps_properties chk_u (.clk, .reset_n, .psel,
	.penable, .prdata, .pready, .pslverr, .pll_locked, .xtal_recal_start,
	.pll_enable, .pll_reference_select, .pll_ready);
